/* File: pdc_pkg.sv */
// Shared constants and types for the power-down and complement unit
//
// Summary of operation
// RL1 - Power-down stops fetch and gates system clock
// RL2 - Memory and registers stay unchanged during power-down
// RL3 - Power-down zeroes watchdog counter and prescaler
// RL4 - Power-down sets power-down flag, clears timeout
// RL5 - Complement operand byte into accumulator
// RL6 - Complement leaves memory operand unmodified
// RL7 - Watchdog clear zeroes counter, clears both flags
// RL8 - Completed pre-clear pair clears both flags
// RL9 - Lone pre-clear leaves both flags unchanged
// RL10 - Four clocks per cycle, extra on PC load
package pdc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLOCKS_PER_CYCLE = 4;
    localparam logic [1:0]  PHASE_RESET      = 2'h0;
    localparam logic [1:0]  PHASE_LAST       = 2'h3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic       POWER_DOWN_RESET = 1'h0;
    localparam logic       TIMEOUT_RESET    = 1'h0;
    localparam logic [7:0] ACC_RESET        = 8'h00;
    localparam logic [7:0] BYTE_ONES        = 8'hFF;
    localparam logic [7:0] BYTE_ZERO        = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NOP                          = 3'b000,
        OP_POWER_DOWN                   = 3'b001,
        OP_WATCHDOG_CLEAR_INSTR         = 3'b010,
        OP_WATCHDOG_PRECLEAR_FIRST_INSTR  = 3'b011,
        OP_WATCHDOG_PRECLEAR_SECOND_INSTR = 3'b100,
        OP_COMPLEMENT_TO_ACCUMULATOR_INSTR = 3'b101
    } op_t;

    typedef enum logic [0:0] {
        ST_RUN    = 1'b0,
        ST_HALTED = 1'b1
    } run_state_t;

    typedef struct packed {
        logic       valid;
        op_t        op;
        logic [7:0] operand;
        logic       extraCycle;
    } instr_t;

    typedef struct packed {
        logic       accWrite;
        logic [7:0] accData;
        logic       zeroFlag;
    } acc_result_t;

endpackage : pdc_pkg

/* File: machine_cycle_timer.sv */
// Divider that marks the last system clock of each machine cycle
module machine_cycle_timer #(
    parameter int unsigned CLOCKS = 4
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic run,
    output logic      cycleEnd
);
    import pdc_pkg::*;

    localparam int unsigned W = (CLOCKS > 1) ? $clog2(CLOCKS) : 1;
    localparam logic [W-1:0] LAST = W'(CLOCKS - 1);

    logic [W-1:0] phase;

    // Held at phase zero while stopped so a wake starts a fresh cycle
    always_ff @(posedge ref_clk) begin
        if (rst || !run) begin
            phase    <= '0;
            cycleEnd <= 1'b0;
        end else begin
            phase    <= (phase == LAST) ? '0 : phase + W'(1);
            cycleEnd <= (phase == LAST - W'(1)) || (CLOCKS == 1);
        end
    end

endmodule : machine_cycle_timer

/* File: power_down_and_complement_exec.sv */
// Execution of power-down, watchdog clear and complement-to-accumulator
module power_down_and_complement_exec #(
    parameter int unsigned CLOCKS_PER_MACHINE_CYCLE = pdc_pkg::CLOCKS_PER_CYCLE
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire pdc_pkg::instr_t      instr,
    input  wire logic                 wakeUp,
    input  wire logic                 timeoutEvent,
    output logic                      instrTaken,
    output pdc_pkg::acc_result_t      accResult,
    output logic                      watchdogCounterClear,
    output logic                      prescalerClear,
    output logic                      power_down_flag,
    output logic                      watchdog_timeout_flag,
    output logic                      sysClockEnable,
    output logic                      fetchEnable
);
    import pdc_pkg::*;

    // ------------------------------------------------------------
    // Machine cycle timing
    // ------------------------------------------------------------
    run_state_t state;
    logic       cycleEnd;
    logic       stallPending;
    logic       take;

    machine_cycle_timer #(
        .CLOCKS (CLOCKS_PER_MACHINE_CYCLE)
    ) u_timer (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .run      (state == ST_RUN),
        .cycleEnd (cycleEnd)
    );

    // Instruction accepted only at a cycle boundary, never while halted
    assign take = instr.valid && cycleEnd && (state == ST_RUN)
                  && !stallPending; // RL10

    // PC load or skip burns one more machine cycle before the next take
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stallPending <= 1'b0;
        end else if (isHalt) begin
            // Pending stall dropped so a wake starts a clean cycle
            stallPending <= 1'b0; // RL1
        end else if (take) begin
            stallPending <= instr.extraCycle; // RL10
        end else if (cycleEnd) begin
            stallPending <= 1'b0; // RL10
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            instrTaken <= 1'b0;
        end else begin
            instrTaken <= take;
        end
    end

    // ------------------------------------------------------------
    // Decode of the taken instruction
    // ------------------------------------------------------------
    logic isHalt;
    logic isClear;
    logic isPreFirst;
    logic isPreSecond;
    logic isCompl;

    // One-hot decode; nothing fires unless the instruction was taken
    always_comb begin
        isHalt      = 1'b0;
        isClear     = 1'b0;
        isPreFirst  = 1'b0;
        isPreSecond = 1'b0;
        isCompl     = 1'b0;
        if (take) begin
            case (instr.op)
                OP_POWER_DOWN: begin
                    isHalt = 1'b1; // RL1
                end
                OP_WATCHDOG_CLEAR_INSTR: begin
                    isClear = 1'b1; // RL7
                end
                OP_WATCHDOG_PRECLEAR_FIRST_INSTR: begin
                    isPreFirst = 1'b1; // RL8
                end
                OP_WATCHDOG_PRECLEAR_SECOND_INSTR: begin
                    isPreSecond = 1'b1; // RL8
                end
                OP_COMPLEMENT_TO_ACCUMULATOR_INSTR: begin
                    isCompl = 1'b1; // RL5
                end
                default: begin
                    isHalt = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Run / power-down state
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state          <= ST_RUN;
            sysClockEnable <= 1'b1;
            fetchEnable    <= 1'b1;
        end else begin
            case (state)
                ST_RUN: begin
                    if (isHalt) begin
                        state          <= ST_HALTED; // RL1
                        sysClockEnable <= 1'b0; // RL1
                        fetchEnable    <= 1'b0; // RL1
                    end
                end
                ST_HALTED: begin
                    if (wakeUp) begin
                        state          <= ST_RUN;
                        sysClockEnable <= 1'b1;
                        fetchEnable    <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pre-clear pairing
    // ------------------------------------------------------------
    // Either order completes the pair; repeating one half does nothing
    logic seenFirst;
    logic seenSecond;
    logic pairDone;

    assign pairDone = (isPreFirst && seenSecond)
                      || (isPreSecond && seenFirst); // RL8

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            seenFirst  <= 1'b0;
            seenSecond <= 1'b0;
        end else if (pairDone || isClear || isHalt) begin
            seenFirst  <= 1'b0;
            seenSecond <= 1'b0;
        end else begin
            if (isPreFirst) begin
                seenFirst <= 1'b1; // RL9
            end
            if (isPreSecond) begin
                seenSecond <= 1'b1; // RL9
            end
        end
    end

    // ------------------------------------------------------------
    // Watchdog and prescaler clear strobes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            watchdogCounterClear <= 1'b0;
            prescalerClear       <= 1'b0;
        end else begin
            watchdogCounterClear <= isHalt || isClear || pairDone; // RL3 RL7
            prescalerClear       <= isHalt; // RL3
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // A timeout arriving with a clear still wins: it must not be lost
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            watchdog_timeout_flag <= TIMEOUT_RESET;
        end else if (timeoutEvent) begin
            watchdog_timeout_flag <= 1'b1;
        end else if (isHalt) begin
            watchdog_timeout_flag <= 1'b0; // RL4
        end else if (isClear || pairDone) begin
            watchdog_timeout_flag <= 1'b0; // RL7 RL8
        end
    end

    // Lone pre-clear falls through: flag keeps its value
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            power_down_flag <= POWER_DOWN_RESET;
        end else if (isHalt) begin
            power_down_flag <= 1'b1; // RL4
        end else if (isClear || pairDone) begin
            power_down_flag <= 1'b0; // RL7 RL8 RL9
        end
    end

    // ------------------------------------------------------------
    // Complement to accumulator
    // ------------------------------------------------------------
    // No memory write port exists, so the operand and all storage stay
    // untouched, including across power-down
    logic [7:0] inverted;

    assign inverted = instr.operand ^ BYTE_ONES; // RL5

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            accResult.accWrite <= 1'b0;
            accResult.accData  <= ACC_RESET;
            accResult.zeroFlag <= 1'b0;
        end else begin
            accResult.accWrite <= isCompl; // RL5 RL6
            if (isCompl) begin
                accResult.accData  <= inverted; // RL5
                accResult.zeroFlag <= (inverted == BYTE_ZERO);
            end
        end
    end // RL2

endmodule : power_down_and_complement_exec

/* File: pdc_checker.sv */
// Port-level assertions for the power-down and complement unit
module pdc_checker #(
    parameter int unsigned CLOCKS_PER_MACHINE_CYCLE = 4
) (
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire pdc_pkg::instr_t      instr,
    input wire logic                 wakeUp,
    input wire logic                 timeoutEvent,
    input wire logic                 instrTaken,
    input wire pdc_pkg::acc_result_t accResult,
    input wire logic                 watchdogCounterClear,
    input wire logic                 prescalerClear,
    input wire logic                 power_down_flag,
    input wire logic                 watchdog_timeout_flag,
    input wire logic                 sysClockEnable,
    input wire logic                 fetchEnable
);
    import pdc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Result cycle of an instruction taken one edge earlier
    sequence took(op_t o);
        instrTaken && $past(instr.op) == o;
    endsequence
    halt_entry_a: assert property (took(OP_POWER_DOWN) |->
        power_down_flag && prescalerClear && watchdogCounterClear
        && !sysClockEnable && !fetchEnable) else $error("bad halt");
    halt_timeout_a: assert property (took(OP_POWER_DOWN)
        ##0 !$past(timeoutEvent) |-> !watchdog_timeout_flag) else $error("to");
    prescaler_cause_a: assert property (prescalerClear |->
        took(OP_POWER_DOWN)) else $error("stray prescaler clear");
    halted_quiet_a: assert property (!fetchEnable |=>
        !instrTaken) else $error("take while halted");
    wake_resume_a: assert property (!sysClockEnable && wakeUp |=>
        sysClockEnable && fetchEnable) else $error("no wake");
    compl_value_a: assert property (
        took(OP_COMPLEMENT_TO_ACCUMULATOR_INSTR) |-> accResult.accWrite
        && accResult.accData == ~$past(instr.operand)) else $error("cpl");
    acc_hold_a: assert property (!accResult.accWrite |->
        $stable(accResult.accData)) else $error("acc changed");
    clear_flags_a: assert property (took(OP_WATCHDOG_CLEAR_INSTR)
        ##0 !$past(timeoutEvent) |-> watchdogCounterClear
        && !power_down_flag && !watchdog_timeout_flag) else $error("clr");
    pair_clear_a: assert property (watchdogCounterClear &&
        !prescalerClear && !$past(timeoutEvent) |-> !power_down_flag
        && !watchdog_timeout_flag) else $error("pair clear");
    flag_hold_a: assert property (!watchdogCounterClear &&
        !prescalerClear && !$past(timeoutEvent) |-> $stable(power_down_flag)
        && $stable(watchdog_timeout_flag)) else $error("flag moved");
    take_spacing_a: assert property (instrTaken |=>
        !instrTaken [*3]) else $error("takes too close");
endmodule : pdc_checker

bind power_down_and_complement_exec pdc_checker #(
    .CLOCKS_PER_MACHINE_CYCLE(CLOCKS_PER_MACHINE_CYCLE)
) pdc_checker_i (.ref_clk(ref_clk), .rst(rst), .instr(instr),
    .wakeUp(wakeUp), .timeoutEvent(timeoutEvent), .instrTaken(instrTaken),
    .accResult(accResult), .watchdogCounterClear(watchdogCounterClear),
    .prescalerClear(prescalerClear), .power_down_flag(power_down_flag),
    .watchdog_timeout_flag(watchdog_timeout_flag),
    .sysClockEnable(sysClockEnable), .fetchEnable(fetchEnable));

/* File: tb.sv */
// Self-checking testbench for the power-down and complement unit
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pdc_pkg::*;
    logic        ref_clk = 0, rst = 1, wakeUp = 0, timeoutEvent = 0;
    instr_t      instr = '0;
    acc_result_t accResult;
    logic        instrTaken, watchdogCounterClear, prescalerClear;
    logic        power_down_flag, watchdog_timeout_flag;
    logic        sysClockEnable, fetchEnable;
    int          num_errors = 0, samples_checked = 0, n;
    always #5 ref_clk = ~ref_clk;
    power_down_and_complement_exec power_down_and_complement_exec_i (
        .ref_clk(ref_clk), .rst(rst), .instr(instr), .wakeUp(wakeUp),
        .timeoutEvent(timeoutEvent), .instrTaken(instrTaken),
        .accResult(accResult), .watchdogCounterClear(watchdogCounterClear),
        .prescalerClear(prescalerClear), .power_down_flag(power_down_flag),
        .watchdog_timeout_flag(watchdog_timeout_flag),
        .sysClockEnable(sysClockEnable), .fetchEnable(fetchEnable));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tick
    // Instruction stays up after the take; caller drops or replaces it
    task automatic issue(input op_t o, input logic [7:0] d, input logic x);
        n = 0;
        instr = '{1'b1, o, d, x};
        do begin
            tick(1);
            n++;
        end while (instrTaken !== 1'b1 && n < 20);
        chk(instrTaken, 8'h01);
    endtask : issue
    task automatic pulse_timeout;
        timeoutEvent = 1;
        tick(1);
        timeoutEvent = 0;
        tick(1);
    endtask : pulse_timeout
    task automatic idle;
        instr.valid = 0;
        tick(1);
    endtask : idle
    // Halt, then wake at once so the power-down flag is left set
    task automatic power_cycle;
        issue(OP_POWER_DOWN, 8'h00, 1'b0);
        instr.valid = 0;
        wakeUp = 1;
        tick(1);
        wakeUp = 0;
        tick(1);
    endtask : power_cycle
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_complement;
        logic [7:0] v [4] = '{8'h00, 8'h0F, 8'hA5, 8'hFF};
        foreach (v[i]) begin
            issue(OP_COMPLEMENT_TO_ACCUMULATOR_INSTR, v[i], 1'b0);
            chk(accResult.accWrite, 8'h01);
            chk(accResult.accData, ~v[i]);
            chk(accResult.zeroFlag, v[i] == 8'hFF);
        end
    endtask : test_complement
    task automatic test_extra;
        issue(OP_NOP, 8'h00, 1'b1);
        issue(OP_COMPLEMENT_TO_ACCUMULATOR_INSTR, 8'h3C, 1'b0);
        chk(8'(n), 8'h08);
        issue(OP_COMPLEMENT_TO_ACCUMULATOR_INSTR, 8'hC3, 1'b0);
        chk(8'(n), 8'h04);
    endtask : test_extra
    task automatic test_halt;
        pulse_timeout();
        issue(OP_POWER_DOWN, 8'h00, 1'b0);
        chk(power_down_flag, 8'h01);
        chk(watchdog_timeout_flag, 8'h00);
        chk({prescalerClear, watchdogCounterClear}, 8'h03);
        chk({sysClockEnable, fetchEnable}, 8'h00);
        instr = '{1'b1, OP_COMPLEMENT_TO_ACCUMULATOR_INSTR, 8'h55, 1'b0};
        repeat (12) begin
            tick(1);
            chk(instrTaken, 8'h00);
        end
        chk(accResult.accData, 8'h3C);
        instr.valid = 0;
        wakeUp = 1;
        tick(1);
        wakeUp = 0;
        tick(1);
        chk({sysClockEnable, fetchEnable}, 8'h03);
        pulse_timeout();
        issue(OP_WATCHDOG_CLEAR_INSTR, 8'h00, 1'b0);
        chk(watchdogCounterClear, 8'h01);
        chk({power_down_flag, watchdog_timeout_flag}, 8'h00);
    endtask : test_halt
    task automatic test_preclear;
        op_t a [2] = '{OP_WATCHDOG_PRECLEAR_FIRST_INSTR,
                       OP_WATCHDOG_PRECLEAR_SECOND_INSTR};
        for (int k = 0; k < 2; k++) begin
            power_cycle();
            pulse_timeout();
            repeat (2) begin
                issue(a[k], 8'h00, 1'b0);
                chk(watchdogCounterClear, 8'h00);
                chk({power_down_flag, watchdog_timeout_flag}, 8'h03);
            end
            issue(a[1-k], 8'h00, 1'b0);
            chk(watchdogCounterClear, 8'h01);
            chk({power_down_flag, watchdog_timeout_flag}, 8'h00);
            idle();
        end
    endtask : test_preclear
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", samples_checked,
                 num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        repeat (2) @(posedge ref_clk);
        #1;
        rst = 0;
        test_complement();
        idle();
        test_extra();
        idle();
        test_halt();
        idle();
        test_preclear();
        finish_test();
    end
    // Whole run needs under two hundred cycles
    initial begin
        #20000;
        num_errors++;
        finish_test();
    end
endmodule : tb
